// *** dv/pso_capture_model.sv ***
// capture logic model standing outside one overhead serial port
`timescale 1ns/1ps
module pso_capture_model (
    input wire logic portClock,
    input wire logic data,
    input wire logic frame,
    input wire logic valid,
    output logic [7:0] gotByte,
    output logic gotFirst,
    output int gotCount
);
    // ****************************************
    // capture
    // ****************************************
    logic [7:0] shift = 8'h00;
    logic lastFrame = 1'h0;
    logic inFirst = 1'h0;
    int bits = 0;
    initial begin
        gotByte = 8'h00;
        gotFirst = 1'h0;
        gotCount = 0;
    end
    always @(posedge portClock) begin
        lastFrame <= frame;
        // drop idle bits, align to frame
        if (valid === 1'h1) begin
            if (frame === 1'h1 && lastFrame !== 1'h1) begin
                bits = 0;
            end
            if (bits == 0) begin
                inFirst = frame;
            end
            shift = {shift[6:0], data};
            bits++;
            if (bits == 8) begin
                gotByte <= shift;
                gotFirst <= inFirst;
                gotCount <= gotCount + 1;
                bits = 0;
            end
        end
    end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the overhead serial output ports
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errTotal++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import pso_pkg::*;
    // ****************************************
    // harness
    // ****************************************
    logic clk, rstn, mapperByteValid, mapperByteReady, rxData, rxClk, rxFrame, rxValid;
    pso_byte_s mapperByte;
    pso_byte_s chanByte [NUM_CHANNELS];
    logic [2:0] chanByteValid, chanByteReady, chData, chClk, chFrame, chValid;
    logic [7:0] gotByte [4];
    logic [3:0] gotFirst;
    int gotCount [4];
    localparam int BIT_CLKS = 2 * PORT_HALF_CYCLES;
    localparam int WAIT_LIMIT = 12 * BIT_CLKS;
    int errTotal = 0, totalChecks = 0, validHigh = 0, validRises = 0, frameHigh = 0;
    logic [11:0] prevLines;
    logic prevClk, prevValid;
    wire logic [11:0] lines = {rxData, rxFrame, rxValid, chData, chFrame, chValid};
    pso_path_overhead_serial_out #(.HALF_CYCLES(PORT_HALF_CYCLES)) u_dut (.clk(clk), .rstn(rstn),
        .mapperByte(mapperByte), .mapperByteValid(mapperByteValid),
        .mapperByteReady(mapperByteReady), .chanByte(chanByte),
        .chanByteValid(chanByteValid), .chanByteReady(chanByteReady),
        .rxOverheadSerialData(rxData), .rxOverheadPortClock(rxClk),
        .rxOverheadFrameMarker(rxFrame), .rxOverheadValidMarker(rxValid),
        .chanOverheadSerialData(chData), .chanOverheadPortClock(chClk),
        .chanOverheadFrameMarker(chFrame), .chanOverheadValidMarker(chValid));
    pso_capture_model u_cap0 (.portClock(rxClk), .data(rxData), .frame(rxFrame),
        .valid(rxValid), .gotByte(gotByte[0]), .gotFirst(gotFirst[0]), .gotCount(gotCount[0]));
    for (genvar i = 0; i < 3; i++) begin : g_cap
        pso_capture_model u_cap (.portClock(chClk[i]), .data(chData[i]), .frame(chFrame[i]),
            .valid(chValid[i]), .gotByte(gotByte[i+1]), .gotFirst(gotFirst[i+1]),
            .gotCount(gotCount[i+1]));
    end
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // lines may only move as their port clock falls; sampled mid-cycle so
    // the check never races the edge that launches them
    always @(negedge clk) begin
        if (rstn === 1'h1) begin
            `CHK((lines !== prevLines) && !(prevClk && !rxClk), 1'h0)
            `CHK(chClk, {3{rxClk}})
            validHigh += int'(chValid[0]);
            validRises += int'(chValid[0] && !prevValid);
            frameHigh += int'(chFrame[0]);
        end
        prevLines = lines;
        prevClk = rxClk;
        prevValid = chValid[0];
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic sendByte(input int p, input logic [7:0] d, input logic f, input logic hold);
        int n;
        n = 0;
        // drive just after an edge, never in the edge's own time step
        @(posedge clk);
        #1;
        if (p == 0) begin
            mapperByte = '{data: d, first: f};
            mapperByteValid = 1'h1;
        end else begin
            chanByte[p-1] = '{data: d, first: f};
            chanByteValid[p-1] = 1'h1;
        end
        do begin
            @(posedge clk);
            n++;
        end while (!(p == 0 ? mapperByteReady : chanByteReady[p-1]) && n < WAIT_LIMIT);
        `CHK(n < WAIT_LIMIT, 1'h1)
        #1;
        if (!hold && p == 0) mapperByteValid = 1'h0;
        if (!hold && p != 0) chanByteValid[p-1] = 1'h0;
    endtask
    task automatic waitByte(input int p, input int cnt, input logic [7:0] d, input logic f);
        int n;
        n = 0;
        while (gotCount[p] != cnt && n < WAIT_LIMIT) begin
            @(posedge clk);
            n++;
        end
        `CHK(gotCount[p], cnt)
        `CHK(gotByte[p], d)
        `CHK(gotFirst[p], f)
    endtask
    task automatic finalReport;
        $display("checks=%0d errors=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // single frame-start byte on the mapper port
    task automatic runSingleByte;
        sendByte(0, 8'ha5, 1'h1, 1'h0);
        waitByte(0, 1, 8'ha5, 1'h1);
    endtask
    // back-to-back bytes keep valid unbroken; frame covers only the first byte
    task automatic runBackToBack;
        fork
            begin
                sendByte(1, 8'h3c, 1'h1, 1'h1);
                sendByte(1, 8'hc3, 1'h0, 1'h1);
                sendByte(1, 8'h01, 1'h0, 1'h0);
            end
            begin
                waitByte(1, 1, 8'h3c, 1'h1);
                waitByte(1, 2, 8'hc3, 1'h0);
                waitByte(1, 3, 8'h01, 1'h0);
            end
        join
        repeat (BIT_CLKS) @(posedge clk);
        `CHK(validRises, 1)
        `CHK(validHigh, 3 * BYTE_BITS * BIT_CLKS)
        `CHK(frameHigh, BYTE_BITS * BIT_CLKS)
    endtask
    // all channels at once, each on its own lines
    task automatic runAllChannels;
        fork
            sendByte(2, 8'h81, 1'h1, 1'h0);
            sendByte(3, 8'h42, 1'h0, 1'h0);
            sendByte(1, 8'h18, 1'h1, 1'h0);
        join
        waitByte(2, 1, 8'h81, 1'h1);
        waitByte(3, 1, 8'h42, 1'h0);
        waitByte(1, 4, 8'h18, 1'h1);
    endtask
    // reset in mid-byte drops the markers; a later frame byte realigns capture
    task automatic runMidReset;
        sendByte(0, 8'h5a, 1'h0, 1'h0);
        repeat (3 * BIT_CLKS) @(posedge clk);
        #1 rstn = 1'h0;
        @(negedge clk);
        `CHK({rxClk, rxValid, rxFrame, chValid, chFrame}, 9'h100)
        repeat (4) @(posedge clk);
        #1 rstn = 1'h1;
        sendByte(0, 8'he7, 1'h1, 1'h0);
        waitByte(0, 2, 8'he7, 1'h1);
    endtask
    // nothing offered: markers stay low
    task automatic runIdle;
        repeat (BIT_CLKS) @(posedge clk);
        repeat (2 * BIT_CLKS) begin
            @(negedge clk);
            `CHK({rxValid, rxFrame, chValid, chFrame}, 8'h00)
        end
    endtask
    initial begin
        rstn = 1'h0;
        mapperByte = '0;
        mapperByteValid = 1'h0;
        chanByte = '{default: '0};
        chanByteValid = 3'h0;
        repeat (12) @(posedge clk);
        `CHK({rxClk, rxValid, chValid}, 5'h10)
        #1 rstn = 1'h1;
        runSingleByte();
        runBackToBack();
        runAllChannels();
        runMidReset();
        runIdle();
        finalReport();
    end
    initial begin
        #80000;
        errTotal++;
        finalReport();
    end
endmodule

// *** inc/pso_pkg.sv ***
// shared constants and types for the path-overhead serial output ports
package pso_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned PORT_CLK_PERIOD_NS = 128;
    localparam int unsigned PORT_HALF_CYCLES = PORT_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ****************************************
    // structure
    // ****************************************
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned NUM_CHANNELS = 3;
    localparam int unsigned NUM_PORTS = NUM_CHANNELS + 1;
    localparam logic [2:0] LAST_BIT_COUNT = 3'h7;
    localparam logic PORT_CLK_RESET = 1'h1;

    typedef struct packed {
        logic [BYTE_BITS-1:0] data;
        logic first;
    } pso_byte_s;

    typedef struct packed {
        logic data;
        logic frame;
        logic valid;
    } pso_line_s;

    typedef enum logic {
        PSO_IDLE,
        PSO_SHIFT
    } pso_state_e;
endpackage

// *** verilog/pso_path_overhead_serial_out.sv ***
// serialiser for the mapper and per-channel receive path-overhead output ports
`timescale 1ns/1ps

// Overview of operation
// - Each port's data, frame and valid lines change only together with that port clock falling.
// - The frame marker is high for exactly the bits of the first overhead byte of a frame.
// - The valid marker is high only while the data line carries real overhead bits.
// - Each port shifts its overhead bytes out one bit per port clock, with independent lines.
// - Channel port bits move on their clock's falling edge and are sampled on its rising edge.
module pso_path_overhead_serial_out #(
    parameter int unsigned HALF_CYCLES = pso_pkg::PORT_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire pso_pkg::pso_byte_s mapperByte,
    input wire logic mapperByteValid,
    output logic mapperByteReady,
    input wire pso_pkg::pso_byte_s chanByte [pso_pkg::NUM_CHANNELS],
    input wire logic [pso_pkg::NUM_CHANNELS-1:0] chanByteValid,
    output logic [pso_pkg::NUM_CHANNELS-1:0] chanByteReady,
    output logic rxOverheadSerialData,
    output logic rxOverheadPortClock,
    output logic rxOverheadFrameMarker,
    output logic rxOverheadValidMarker,
    output logic [pso_pkg::NUM_CHANNELS-1:0] chanOverheadSerialData,
    output logic [pso_pkg::NUM_CHANNELS-1:0] chanOverheadPortClock,
    output logic [pso_pkg::NUM_CHANNELS-1:0] chanOverheadFrameMarker,
    output logic [pso_pkg::NUM_CHANNELS-1:0] chanOverheadValidMarker
);
    import pso_pkg::*;

    localparam int unsigned CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

    // ****************************************
    // port clock divider
    // ****************************************
    logic [CNT_W-1:0] divCnt;
    logic [CNT_W-1:0] next_divCnt;
    logic portClk;
    logic next_portClk;
    logic fallEv;

    // one divider feeds every port; the ports stay independent in data,
    // but sharing the clock costs nothing and keeps their edges aligned
    always_comb begin
        fallEv = 1'b0;
        next_divCnt = divCnt + CNT_W'(1);
        next_portClk = portClk;
        if (divCnt == CNT_LAST) begin
            next_divCnt = '0;
            next_portClk = ~portClk;
            fallEv = portClk;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt <= '0;
            portClk <= PORT_CLK_RESET;
        end else begin
            divCnt <= next_divCnt;
            portClk <= next_portClk;
        end
    end

    // ****************************************
    // per-port shifters
    // ****************************************
    pso_byte_s inByte [NUM_PORTS];
    logic [NUM_PORTS-1:0] inValid;
    logic [NUM_PORTS-1:0] ready;
    pso_state_e state [NUM_PORTS];
    pso_state_e next_state [NUM_PORTS];
    logic [BYTE_BITS-1:0] shiftReg [NUM_PORTS];
    logic [BYTE_BITS-1:0] next_shiftReg [NUM_PORTS];
    logic [2:0] bitCnt [NUM_PORTS];
    logic [2:0] next_bitCnt [NUM_PORTS];
    logic [NUM_PORTS-1:0] firstByte;
    logic [NUM_PORTS-1:0] next_firstByte;
    pso_line_s line [NUM_PORTS];
    pso_line_s next_line [NUM_PORTS];

    always_comb begin
        inByte[0] = mapperByte;
        inValid[0] = mapperByteValid;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            inByte[i+1] = chanByte[i];
            inValid[i+1] = chanByteValid[i];
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_state[p] = state[p];
            next_shiftReg[p] = shiftReg[p];
            next_bitCnt[p] = bitCnt[p];
            next_firstByte[p] = firstByte[p];
            next_line[p] = line[p];
            ready[p] = 1'b0;
            if (fallEv) begin
                unique case (state[p])
                    PSO_SHIFT: begin
                        if (bitCnt[p] != 3'h0) begin
                            next_shiftReg[p] = {shiftReg[p][BYTE_BITS-2:0], 1'b0};
                            next_bitCnt[p] = bitCnt[p] - 3'h1;
                            next_line[p] = '{data: shiftReg[p][BYTE_BITS-2],
                                             frame: firstByte[p], valid: 1'b1};
                        end else begin
                            next_state[p] = PSO_IDLE;
                        end
                    end
                    PSO_IDLE: begin
                    end
                endcase
                // a new byte is taken at the byte boundary, so bytes run back to back
                if (state[p] == PSO_IDLE || bitCnt[p] == 3'h0) begin
                    if (inValid[p]) begin
                        ready[p] = 1'b1;
                        next_state[p] = PSO_SHIFT;
                        next_shiftReg[p] = inByte[p].data;
                        next_bitCnt[p] = LAST_BIT_COUNT;
                        next_firstByte[p] = inByte[p].first;
                        next_line[p] = '{data: inByte[p].data[BYTE_BITS-1],
                                         frame: inByte[p].first, valid: 1'b1};
                    end else begin
                        next_line[p] = '{data: 1'b0, frame: 1'b0, valid: 1'b0};
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                state[p] <= PSO_IDLE;
                shiftReg[p] <= '0;
                bitCnt[p] <= 3'h0;
                line[p] <= '0;
            end
            firstByte <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                state[p] <= next_state[p];
                shiftReg[p] <= next_shiftReg[p];
                bitCnt[p] <= next_bitCnt[p];
                line[p] <= next_line[p];
            end
            firstByte <= next_firstByte;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    // mapper and per-channel clock, lines and ready
    always_comb begin
        mapperByteReady = ready[0];
        rxOverheadSerialData = line[0].data;
        rxOverheadPortClock = portClk;
        rxOverheadFrameMarker = line[0].frame;
        rxOverheadValidMarker = line[0].valid;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            chanByteReady[i] = ready[i+1];
            chanOverheadSerialData[i] = line[i+1].data;
            chanOverheadPortClock[i] = portClk;
            chanOverheadFrameMarker[i] = line[i+1].frame;
            chanOverheadValidMarker[i] = line[i+1].valid;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    for (genvar g = 0; g < NUM_PORTS; g++) begin : gChk
        property p_change_on_fall;
            @(posedge clk) disable iff (!rstn) $changed(line[g]) |-> $fell(portClk);
        endproperty
        a_change_on_fall: assert property (p_change_on_fall) else $error("line moved off fall");

        property p_stable_on_rise;
            @(posedge clk) disable iff (!rstn) $rose(portClk) |-> $stable(line[g]);
        endproperty
        a_stable_on_rise: assert property (p_stable_on_rise) else $error("line moved on rise");

        property p_frame_needs_valid;
            @(posedge clk) disable iff (!rstn) line[g].frame |-> line[g].valid;
        endproperty
        a_frame_needs_valid: assert property (p_frame_needs_valid) else $error("frame w/o valid");

        property p_frame_on_first;
            @(posedge clk) disable iff (!rstn)
                ready[g] |=> (line[g].frame == $past(inByte[g].first));
        endproperty
        a_frame_on_first: assert property (p_frame_on_first) else $error("frame not on J1");

        property p_frame_ends_at_byte;
            @(posedge clk) disable iff (!rstn) $fell(line[g].frame) |-> $past(bitCnt[g]) == 3'h0;
        endproperty
        a_frame_ends_at_byte: assert property (p_frame_ends_at_byte) else $error("frame cut");

        property p_valid_ends_at_byte;
            @(posedge clk) disable iff (!rstn) $fell(line[g].valid) |-> $past(bitCnt[g]) == 3'h0;
        endproperty
        a_valid_ends_at_byte: assert property (p_valid_ends_at_byte) else $error("valid cut");

        property p_load_msb;
            @(posedge clk) disable iff (!rstn)
                ready[g] |=> line[g].valid && (line[g].data == $past(inByte[g].data[BYTE_BITS-1]));
        endproperty
        a_load_msb: assert property (p_load_msb) else $error("first bit wrong");

        property p_next_bit;
            @(posedge clk) disable iff (!rstn)
                (fallEv && state[g] == PSO_SHIFT && bitCnt[g] != 3'h0)
                |=> line[g].data == $past(shiftReg[g][BYTE_BITS-2]);
        endproperty
        a_next_bit: assert property (p_next_bit) else $error("shift bit wrong");

        c_first_byte: cover property (@(posedge clk) disable iff (!rstn) ready[g] && inByte[g].first);
        c_back_to_back: cover property (@(posedge clk) disable iff (!rstn)
            ready[g] ##1 (!ready[g])[*1] ##[1:300] ready[g]);
        c_gap: cover property (@(posedge clk) disable iff (!rstn) $fell(line[g].valid));
    end
endmodule
